// [hdl/afesr_bank.sv]
// Setup register bank with output latency line, inversion and auto-cycle colour counter
`timescale 1ns/1ps
`default_nettype none

module afesr_bank (
	input wire logic ref_clk,
	input wire logic rst,
	input wire afesr_pkg::afesr_req_s req,
	input wire logic row_sequential_operation,
	input wire logic fast_row_mode,
	input wire logic autocycle_step,
	input wire logic [afesr_pkg::DATA_W-1:0] adc_data,
	output logic [7:0] rd_data,
	output var afesr_pkg::afesr_ctrl_s ctrl,
	output var afesr_pkg::afesr_colour_e autocycle_colour,
	output logic [afesr_pkg::DATA_W-1:0] data_out
);
	import afesr_pkg::*;

	typedef struct packed {
		logic [7:0] setup_one_power_sampling;
		logic [7:0] setup_two_output_reference;
		logic [7:0] setup_three_clamp_timing;
		afesr_ctrl_s ctrl;
		afesr_colour_e colour;
		logic [7:0] rd_data;
		logic [DLINE_DEPTH-1:0][DATA_W-1:0] dline;
		logic [DATA_W-1:0] data_out;
	} afesr_state_s;

	afesr_state_s s_q;
	afesr_state_s s_d;
	logic [DATA_W-1:0] tap;

	// Output latency in master clocks from the code and the ADC period
	function automatic logic [LAT_W-1:0] latency_cycles(input logic [1:0] code, input logic fast);
		logic [LAT_W-1:0] period;
		period = fast ? ADC_PERIOD_FAST_ROW : ADC_PERIOD_NORMAL;
		latency_cycles = 4'({2'h0, code} * period);
	endfunction : latency_cycles

	// Effective controls seen by the analogue blocks and the output stage
	function automatic afesr_ctrl_s derive_ctrl(input logic [7:0] r1, input logic [7:0] r2,
			input logic [7:0] r3, input logic row_seq, input logic fast);
		afesr_ctrl_s c;
		c = '0;
		// Under selective power down the on bit is ignored and blocks stay up by default
		c.global_power_on = r1[B_SELECTIVE_POWERDOWN] | r1[B_GLOBAL_ON];
		c.block_disable_enable = r1[B_SELECTIVE_POWERDOWN];
		c.cds_mode = r1[B_CDS];
		// Row sequential timing only works with mono on and red selected
		c.mono_mode = row_seq | r1[B_MONO];
		c.mono_input_select = row_seq ? MONO_SELECT_RED : r3[B_MONO_SELECT_LO +: 2];
		c.amp_output_offset = r1[B_AMP_OFFSET_LO +: 2];
		c.fastest_mode_flag = r1[B_FASTEST_MODE];
		c.output_word_format = r2[B_FORMAT_LO +: 2];
		c.output_invert = r2[B_OUTPUT_INVERT];
		c.reference_dac_hiz = r2[B_EXTERNAL_REFERENCE];
		c.reference_dac_span = r2[B_DAC_SPAN];
		c.reference_dac_code = r3[B_DAC_CODE_LO +: 4];
		c.cds_reset_shift = r3[B_CDS_SHIFT_LO +: 2];
		c.output_latency_cycles = latency_cycles(r2[B_LATENCY_LO +: 2], fast);
		derive_ctrl = c;
	endfunction : derive_ctrl

	// Every cell returns here on hard reset; a soft reset loads it too but re-derives the controls and raises soft_reset_pulse
	function automatic afesr_state_s reset_state();
		afesr_state_s r;
		r = '0;
		r.setup_one_power_sampling = SETUP_ONE_DEFAULT;
		r.setup_two_output_reference = SETUP_TWO_DEFAULT;
		r.setup_three_clamp_timing = SETUP_THREE_DEFAULT;
		r.ctrl = derive_ctrl(SETUP_ONE_DEFAULT, SETUP_TWO_DEFAULT, SETUP_THREE_DEFAULT, 1'b0, 1'b0);
		r.colour = COLOUR_RED;
		r.rd_data = READ_UNMAPPED;
		reset_state = r;
	endfunction : reset_state

	// Next state: data line, colour counter, register writes, strobes and read answer
	always_comb begin
		s_d = s_q;
		tap = s_q.dline[s_q.ctrl.output_latency_cycles];
		// Latency line; tap zero is minimum latency
		s_d.dline[0] = adc_data;
		for (int i = 1; i < DLINE_DEPTH; i++) begin
			s_d.dline[i] = s_q.dline[i-1];
		end
		s_d.data_out = s_q.ctrl.output_invert ? ~tap : tap;
		// Colour counter advanced by the auto-cycle input pulse
		if (autocycle_step) begin
			case (s_q.colour)
				COLOUR_RED: s_d.colour = COLOUR_GREEN;
				COLOUR_GREEN: s_d.colour = COLOUR_BLUE;
				default: s_d.colour = COLOUR_RED;
			endcase
		end
		s_d.rd_data = READ_UNMAPPED;
		if (req.rd_en) begin
			case (req.addr)
				ADDR_SETUP_ONE: s_d.rd_data = s_q.setup_one_power_sampling;
				ADDR_SETUP_TWO: s_d.rd_data = s_q.setup_two_output_reference;
				ADDR_SETUP_THREE: s_d.rd_data = s_q.setup_three_clamp_timing;
				default: s_d.rd_data = READ_UNMAPPED; // Strobes are write only
			endcase
		end
		if (req.wr_en) begin
			case (req.addr)
				ADDR_SETUP_ONE: s_d.setup_one_power_sampling = req.wdata & SETUP_ONE_MASK;
				ADDR_SETUP_TWO: s_d.setup_two_output_reference = req.wdata & SETUP_TWO_MASK;
				ADDR_SETUP_THREE: s_d.setup_three_clamp_timing = req.wdata & SETUP_THREE_MASK;
				ADDR_AUTOCYCLE_RESET: s_d.colour = COLOUR_RED;
				default: s_d.colour = s_d.colour;
			endcase
		end
		s_d.ctrl = derive_ctrl(s_d.setup_one_power_sampling, s_d.setup_two_output_reference,
			s_d.setup_three_clamp_timing, row_sequential_operation, fast_row_mode);
		// Strobe pulses last one cycle and leave nothing stored
		s_d.ctrl.autocycle_reset_pulse = req.wr_en && (req.addr == ADDR_AUTOCYCLE_RESET);
		// Soft reset overrides everything else taken in the same cycle
		if (req.wr_en && (req.addr == ADDR_SOFT_RESET)) begin
			s_d = reset_state();
			// Forced mono settings still follow row sequential operation through a soft reset
			s_d.ctrl = derive_ctrl(SETUP_ONE_DEFAULT, SETUP_TWO_DEFAULT, SETUP_THREE_DEFAULT,
				row_sequential_operation, fast_row_mode);
			s_d.ctrl.soft_reset_pulse = 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= reset_state();
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rd_data;
	assign ctrl = s_q.ctrl;
	assign autocycle_colour = s_q.colour;
	assign data_out = s_q.data_out;

	// Bus sequences; the write one is shared by several checks, the read one serves the readback check
	sequence s_write(logic [ADDR_W-1:0] a);
		req.wr_en && req.addr == a;
	endsequence

	sequence s_read(logic [ADDR_W-1:0] a);
		req.rd_en && !req.wr_en && req.addr == a;
	endsequence

	property p_global_power;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SETUP_ONE) |=> ctrl.global_power_on ==
			($past(req.wdata[B_SELECTIVE_POWERDOWN]) || $past(req.wdata[B_GLOBAL_ON]));
	endproperty
	a_global_power: assert property (p_global_power) else $error("global power wrong after setup one write");

	property p_setup_one_readback;
		@(posedge ref_clk) disable iff (rst)
		// Readback after one idle cycle with no write in it
		s_write(ADDR_SETUP_ONE) ##1 !req.wr_en ##1 s_read(ADDR_SETUP_ONE) |=>
			rd_data == ($past(req.wdata, 3) & SETUP_ONE_MASK) && ctrl.cds_mode == rd_data[B_CDS];
	endproperty
	a_setup_one_readback: assert property (p_setup_one_readback) else $error("setup one readback mismatch");

	property p_mono_forced;
		@(posedge ref_clk) disable iff (rst)
		row_sequential_operation |=> ctrl.mono_mode && ctrl.mono_input_select == MONO_SELECT_RED;
	endproperty
	a_mono_forced: assert property (p_mono_forced) else $error("mono not forced in row mode");

	property p_soft_reset;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SOFT_RESET) |=> ctrl.soft_reset_pulse
			&& ctrl.reference_dac_code == SETUP_THREE_DEFAULT[B_DAC_CODE_LO +: 4]
			&& ctrl.reference_dac_span && ctrl.cds_mode && ctrl.mono_mode == $past(row_sequential_operation)
			&& autocycle_colour == COLOUR_RED;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");

	property p_strobe_single;
		@(posedge ref_clk) disable iff (rst)
		ctrl.soft_reset_pulse |-> $past(req.wr_en) && $past(req.addr) == ADDR_SOFT_RESET;
	endproperty
	a_strobe_single: assert property (p_strobe_single) else $error("soft reset pulse without write");

	property p_autocycle;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_AUTOCYCLE_RESET) |=> autocycle_colour == COLOUR_RED && ctrl.autocycle_reset_pulse
			##1 !ctrl.autocycle_reset_pulse || $past(req.wr_en);
	endproperty
	a_autocycle: assert property (p_autocycle) else $error("auto-cycle reset failed");

	property p_invert_min;
		@(posedge ref_clk) disable iff (rst)
		(ctrl.output_latency_cycles == 4'h0 && ctrl.output_invert && !(req.wr_en && req.addr == ADDR_SOFT_RESET))
			|=> data_out == ~$past(s_q.dline[0]);
	endproperty
	a_invert_min: assert property (p_invert_min) else $error("inverted output wrong");

	sequence s_lat2_normal;
		(s_q.setup_two_output_reference[B_LATENCY_LO +: 2] == 2'h2 && !fast_row_mode
			&& !s_q.setup_two_output_reference[B_OUTPUT_INVERT] && !req.wr_en) [*6];
	endsequence

	property p_latency_two;
		@(posedge ref_clk) disable iff (rst)
		s_lat2_normal |=> data_out == $past(adc_data, 6);
	endproperty
	a_latency_two: assert property (p_latency_two) else $error("latency code 10 delay wrong");

	sequence s_lat1_fast;
		(s_q.setup_two_output_reference[B_LATENCY_LO +: 2] == 2'h1 && fast_row_mode
			&& !s_q.setup_two_output_reference[B_OUTPUT_INVERT] && !req.wr_en) [*5];
	endsequence

	property p_latency_fast;
		@(posedge ref_clk) disable iff (rst)
		s_lat1_fast |=> data_out == $past(adc_data, 5);
	endproperty
	a_latency_fast: assert property (p_latency_fast) else $error("fast row latency wrong");

	property p_reference_dac;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SETUP_TWO) |=> ctrl.reference_dac_hiz == $past(req.wdata[B_EXTERNAL_REFERENCE])
			&& ctrl.output_word_format == $past(req.wdata[B_FORMAT_LO +: 2]) && rd_data[4] == 1'b0;
	endproperty
	a_reference_dac: assert property (p_reference_dac) else $error("setup two fields not applied");

	// Setup one fields land in the controls one cycle after the write
	property p_one_fields;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SETUP_ONE) ##0 !row_sequential_operation |=>
			ctrl.mono_mode == $past(req.wdata[B_MONO])
			&& ctrl.block_disable_enable == $past(req.wdata[B_SELECTIVE_POWERDOWN])
			&& ctrl.amp_output_offset == $past(req.wdata[B_AMP_OFFSET_LO +: 2])
			&& ctrl.fastest_mode_flag == $past(req.wdata[B_FASTEST_MODE]);
	endproperty
	a_one_fields: assert property (p_one_fields) else $error("setup one fields wrong");

	// Inversion and reference span follow setup two directly
	property p_two_fields;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SETUP_TWO) |=> ctrl.output_invert == $past(req.wdata[B_OUTPUT_INVERT])
			&& ctrl.reference_dac_span == $past(req.wdata[B_DAC_SPAN]);
	endproperty
	a_two_fields: assert property (p_two_fields) else $error("setup two invert or span wrong");

	// Latency in master clocks is the code times the ADC period of the mode in force
	property p_latency_code;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SETUP_TWO) |=> ctrl.output_latency_cycles == $past(req.wdata[B_LATENCY_LO +: 2])
			* ($past(fast_row_mode) ? ADC_PERIOD_FAST_ROW : ADC_PERIOD_NORMAL);
	endproperty
	a_latency_code: assert property (p_latency_code) else $error("latency count wrong");

	// Setup three fields pass through outside row sequential operation
	property p_three_fields;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SETUP_THREE) ##0 !row_sequential_operation |=>
			ctrl.reference_dac_code == $past(req.wdata[B_DAC_CODE_LO +: 4])
			&& ctrl.cds_reset_shift == $past(req.wdata[B_CDS_SHIFT_LO +: 2])
			&& ctrl.mono_input_select == $past(req.wdata[B_MONO_SELECT_LO +: 2]);
	endproperty
	a_three_fields: assert property (p_three_fields) else $error("setup three fields wrong");

	// Hard reset leaves every control at its default
	property p_reset_defaults;
		@(posedge ref_clk)
		rst |=> ctrl.cds_mode && !ctrl.mono_mode && ctrl.reference_dac_span && !ctrl.soft_reset_pulse
			&& ctrl.reference_dac_code == SETUP_THREE_DEFAULT[B_DAC_CODE_LO +: 4]
			&& ctrl.cds_reset_shift == SETUP_THREE_DEFAULT[B_CDS_SHIFT_LO +: 2] && rd_data == READ_UNMAPPED;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

	// Write-only addresses answer a read with nothing
	property p_strobe_read;
		@(posedge ref_clk) disable iff (rst)
		req.rd_en && (req.addr == ADDR_SOFT_RESET || req.addr == ADDR_AUTOCYCLE_RESET) |=> rd_data == READ_UNMAPPED;
	endproperty
	a_strobe_read: assert property (p_strobe_read) else $error("strobe address read not zero");

	// The read answer stands for one cycle only
	property p_read_idle;
		@(posedge ref_clk) disable iff (rst)
		!req.rd_en |=> rd_data == READ_UNMAPPED;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read answer outlived its cycle");

	// Each step taken with no write in the same cycle moves the colour counter on, blue wrapping back to red
	property p_colour_step;
		@(posedge ref_clk) disable iff (rst)
		autocycle_step && !req.wr_en |=> autocycle_colour != $past(autocycle_colour)
			&& (autocycle_colour == COLOUR_RED) == ($past(autocycle_colour) == COLOUR_BLUE);
	endproperty
	a_colour_step: assert property (p_colour_step) else $error("colour counter step wrong");

	// The reset strobe wins over a step taken in the same cycle
	property p_strobe_beats_step;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_AUTOCYCLE_RESET) ##0 autocycle_step |=> autocycle_colour == COLOUR_RED;
	endproperty
	a_strobe_beats_step: assert property (p_strobe_beats_step) else $error("step beat the strobe");

	// A soft reset clears the latency line and the output word
	property p_soft_clears_line;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_SOFT_RESET) |=> data_out == '0 && s_q.dline == '0 && !ctrl.autocycle_reset_pulse;
	endproperty
	a_soft_clears_line: assert property (p_soft_clears_line) else $error("soft reset left data behind");

	// A lone soft reset write gives exactly one pulse
	sequence s_soft_then_idle;
		s_write(ADDR_SOFT_RESET) ##1 !req.wr_en;
	endsequence

	property p_soft_pulse_once;
		@(posedge ref_clk) disable iff (rst)
		s_soft_then_idle |=> !ctrl.soft_reset_pulse;
	endproperty
	a_soft_pulse_once: assert property (p_soft_pulse_once) else $error("soft reset pulse too long");

	// Auto-cycle reset strobe writes leave the setup registers untouched
	property p_strobe_no_state;
		@(posedge ref_clk) disable iff (rst)
		s_write(ADDR_AUTOCYCLE_RESET) |=> $stable(s_q.setup_one_power_sampling)
			&& $stable(s_q.setup_two_output_reference) && $stable(s_q.setup_three_clamp_timing);
	endproperty
	a_strobe_no_state: assert property (p_strobe_no_state) else $error("strobe write changed a register");

	// Writes outside the map change nothing
	property p_unmapped_write;
		@(posedge ref_clk) disable iff (rst)
		req.wr_en && req.addr > ADDR_AUTOCYCLE_RESET |=> $stable(s_q.setup_one_power_sampling)
			&& $stable(s_q.setup_two_output_reference) && $stable(s_q.setup_three_clamp_timing);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a register");
endmodule : afesr_bank

`default_nettype wire

// [hdl/afesr_pkg.sv]
// Package for the front end setup register bank: addresses, fields, defaults and carrier types
package afesr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 14;
	localparam int DLINE_DEPTH = 10;
	localparam int LAT_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_ONE = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_TWO = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_THREE = 6'h03;
	localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 6'h04;
	localparam logic [ADDR_W-1:0] ADDR_AUTOCYCLE_RESET = 6'h05;
	localparam logic [7:0] SETUP_ONE_DEFAULT = 8'h03;
	localparam logic [7:0] SETUP_TWO_DEFAULT = 8'h20;
	localparam logic [7:0] SETUP_THREE_DEFAULT = 8'h1F;
	localparam logic [7:0] SETUP_ONE_MASK = 8'h7F;
	localparam logic [7:0] SETUP_TWO_MASK = 8'hEF;
	localparam logic [7:0] SETUP_THREE_MASK = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Setup one fields
	localparam int B_GLOBAL_ON = 0;
	localparam int B_CDS = 1;
	localparam int B_MONO = 2;
	localparam int B_SELECTIVE_POWERDOWN = 3;
	localparam int B_AMP_OFFSET_LO = 4;
	localparam int B_FASTEST_MODE = 6;
	// Setup two fields
	localparam int B_FORMAT_LO = 0;
	localparam int B_OUTPUT_INVERT = 2;
	localparam int B_EXTERNAL_REFERENCE = 3;
	localparam int B_DAC_SPAN = 5;
	localparam int B_LATENCY_LO = 6;
	// Setup three fields
	localparam int B_DAC_CODE_LO = 0;
	localparam int B_CDS_SHIFT_LO = 4;
	localparam int B_MONO_SELECT_LO = 6;
	// Master clock periods per ADC clock period
	localparam logic [LAT_W-1:0] ADC_PERIOD_NORMAL = 4'h2;
	localparam logic [LAT_W-1:0] ADC_PERIOD_FAST_ROW = 4'h3;
	localparam logic [1:0] MONO_SELECT_RED = 2'h0;

	typedef enum logic [1:0] {COLOUR_RED, COLOUR_GREEN, COLOUR_BLUE} afesr_colour_e;

	typedef struct packed {
		logic global_power_on;
		logic block_disable_enable;
		logic cds_mode;
		logic mono_mode;
		logic [1:0] amp_output_offset;
		logic fastest_mode_flag;
		logic [1:0] output_word_format;
		logic output_invert;
		logic reference_dac_hiz;
		logic reference_dac_span;
		logic [3:0] reference_dac_code;
		logic [1:0] cds_reset_shift;
		logic [1:0] mono_input_select;
		logic [LAT_W-1:0] output_latency_cycles;
		logic soft_reset_pulse;
		logic autocycle_reset_pulse;
	} afesr_ctrl_s;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} afesr_req_s;
endpackage : afesr_pkg

// [testbench/afesr_host.sv]
// Host controller model that drives the setup register port of the bank
`timescale 1ns/1ps
`default_nettype none
module afesr_host (
	input wire logic ref_clk,
	output var afesr_pkg::afesr_req_s req
);
	import afesr_pkg::*;
	// Port starts idle with no strobe raised
	initial begin
		req = '0;
	end
	// One access: launched after a falling edge, held over the taking edge, then released
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		req.wr_en = w;
		req.rd_en = !w;
		req.addr = a;
		req.wdata = d;
		@(negedge ref_clk);
		req.wr_en = 1'b0;
		req.rd_en = 1'b0;
		// Released lines flip so a stale address never looks valid
		req.addr = ~a;
		req.wdata = ~d;
	endtask : access
	// Software reset before any other setup write
	task automatic power_up();
		access(1'b1, ADDR_SOFT_RESET, 8'hA5);
	endtask : power_up
endmodule : afesr_host
`default_nettype wire

// [testbench/afesr_bank_bench.sv]
// Self-checking bench for the setup register bank
`timescale 1ns/1ps
`default_nettype none
module afesr_bank_bench;
	import afesr_pkg::*;
	logic ref_clk, rst, row_seq, fast, step, rd_pend;
	logic [DATA_W-1:0] adc, data_out;
	logic [7:0] rd_data;
	afesr_req_s req;
	afesr_ctrl_s ctrl;
	afesr_colour_e colour;
	logic [31:0] seed;
	logic [7:0] rdq[$];
	int error_cnt, checked;
	afesr_host i_host (.ref_clk(ref_clk), .req(req));
	afesr_bank i_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .row_sequential_operation(row_seq),
		.fast_row_mode(fast), .autocycle_step(step), .adc_data(adc), .rd_data(rd_data), .ctrl(ctrl),
		.autocycle_colour(colour), .data_out(data_out));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		i_host.access(1'b1, a, d);
	endtask : wr
	// Expected answer is noted before the read goes out
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		rdq.push_back(exp);
		i_host.access(1'b0, a, 8'h00);
	endtask : rd
	// Read taken flag, set at the edge that takes the read
	always @(posedge ref_clk) begin
		rd_pend <= req.rd_en && !rst;
	end
	// Answer stands until the next rising edge; compared at the falling edge in between
	always @(negedge ref_clk) begin
		if (rd_pend) begin
			if (rdq.size() == 0) chk("rd_data unexpected", 16'h0, 16'hFFFF);
			else chk("rd_data", 16'(rdq.pop_front()), 16'(rd_data));
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Watchdog so a stuck wait still reaches the verdict
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		close_out();
	end
	initial begin
		logic [7:0] d;
		logic [1:0] k;
		logic [DATA_W-1:0] v, e;
		logic inv;
		int n, r;
		rst = 1'b1; row_seq = 1'b0; fast = 1'b0; step = 1'b0; adc = '0;
		seed = 32'hBDD089F1; error_cnt = 0; checked = 0;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		rd(ADDR_SETUP_ONE, 8'h03);
		rd(ADDR_SETUP_TWO, 8'h20);
		rd(ADDR_SETUP_THREE, 8'h1F);
		chk("shift default", 16'(ctrl.cds_reset_shift), 16'h1);
		i_host.power_up();
		chk("soft pulse", 16'(ctrl.soft_reset_pulse), 16'h1);
		rd(ADDR_SOFT_RESET, 8'h00);
		// Random setup contents with offset, format, latency and shift codes swept; fields decoded back
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			r = i % 3;
			k = 2'(i / 3);
			if (r == 0) begin
				d[6] = 1'b0;
				d[5:4] = k;
				wr(ADDR_SETUP_ONE, d);
				chk("setup one", 16'({ctrl.global_power_on, ctrl.block_disable_enable, ctrl.cds_mode, ctrl.mono_mode,
					ctrl.amp_output_offset}), 16'({d[3] | d[0], d[3], d[1], d[2], d[5:4]}));
				rd(ADDR_SETUP_ONE, d & 8'h7F);
			end else if (r == 1) begin
				d[1:0] = k;
				d[7:6] = k;
				wr(ADDR_SETUP_TWO, d);
				chk("setup two", 16'({ctrl.output_word_format, ctrl.output_invert, ctrl.reference_dac_hiz,
					ctrl.reference_dac_span}), 16'({d[1:0], d[2], d[3], d[5]}));
				chk("latency", 16'(ctrl.output_latency_cycles), 16'(k) * 16'h2);
				rd(ADDR_SETUP_TWO, d & 8'hEF);
			end else begin
				d[5:4] = k;
				d[7:6] = 2'(i / 3 % 3);
				wr(ADDR_SETUP_THREE, d);
				chk("setup three", 16'({ctrl.mono_input_select, ctrl.cds_reset_shift, ctrl.reference_dac_code}),
					16'(d));
				rd(ADDR_SETUP_THREE, d);
			end
		end
		wr(ADDR_SETUP_ONE, 8'h45);
		chk("fastest flag", 16'(ctrl.fastest_mode_flag), 16'h1);
		// Row sequential mode overrides the stored mono settings
		wr(ADDR_SETUP_THREE, 8'h80);
		row_seq = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("row mono", 16'({ctrl.mono_mode, ctrl.mono_input_select}), 16'h4);
		rd(ADDR_SETUP_THREE, 8'h80);
		// Colour counter steps, then the strobe wins over a step in the same cycle
		for (int i = 0; i < 4; i++) begin
			step = 1'b1;
			@(negedge ref_clk);
			step = 1'b0;
			chk("colour", 16'(colour), 16'((i + 1) % 3));
		end
		fork
			wr(ADDR_AUTOCYCLE_RESET, 8'h3C);
			begin
				@(negedge ref_clk);
				step = 1'b1;
				@(negedge ref_clk);
				step = 1'b0;
			end
		join
		chk("strobe red", 16'({colour, ctrl.autocycle_reset_pulse}), 16'h1);
		@(negedge ref_clk);
		chk("strobe once", 16'(ctrl.autocycle_reset_pulse), 16'h0);
		row_seq = 1'b0;
		// Latency for every code in both period lengths, impulse timed through the data path
		for (int i = 0; i < 8; i++) begin
			k = 2'(i / 2);
			fast = i[0];
			// Polarity varies so both delay checks and the inverted path all get exercised
			inv = k[0] ^ fast;
			wr(ADDR_SETUP_TWO, {k, 3'b000, inv, 2'b00});
			@(negedge ref_clk);
			chk("latency cycles", 16'(ctrl.output_latency_cycles), 16'(k) * (fast ? 16'h3 : 16'h2));
			repeat (12) @(negedge ref_clk);
			seed = lfsr(seed);
			v = {1'b0, seed[12:0]} | 14'h0001;
			e = inv ? ~v : v;
			adc = v;
			for (n = 1; n < 20; n++) begin
				@(negedge ref_clk);
				adc = '0;
				if (data_out === e) break;
			end
			chk("data delay", 16'(n), 16'(k) * (fast ? 16'h3 : 16'h2) + 16'h2);
		end
		// Software reset puts every register back to its default
		wr(ADDR_SOFT_RESET, 8'h00);
		wr(6'h3F, 8'hFF);
		rd(ADDR_SETUP_ONE, 8'h03);
		rd(ADDR_SETUP_TWO, 8'h20);
		rd(ADDR_SETUP_THREE, 8'h1F);
		rd(6'h3F, 8'h00);
		repeat (3) @(negedge ref_clk);
		chk("queue drained", 16'(rdq.size()), 16'h0);
		close_out();
	end
endmodule : afesr_bank_bench
`default_nettype wire
